//--- hw/tief_top.sv
// timer input edge select, noise filter, counters and AXI4-Lite registers
// Operation
// - edge codes: 00 fall, 01 rise, 11 both
// - edge fields at bits 7:6, 3:2, 1:0
// - registers are accessed as whole bytes
// - each channel filters its input pins
// - width codes: through, 2, 3, 5 ticks
// - capture edge latches counter, raises request
// - external source counts on selected edges
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module tief_top (
	input wire logic clk,
	input wire logic reset,
	// AXI4-Lite write address
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] awaddr,
	// AXI4-Lite write data
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	// AXI4-Lite write response
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// AXI4-Lite read address
	input wire logic arvalid,
	output logic arready,
	input wire logic [31:0] araddr,
	// AXI4-Lite read data
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	// timer input pins, one per channel
	input wire logic [tief_pkg::NCH-1:0] captureInput0,
	input wire logic [tief_pkg::NCH-1:0] captureInput1,
	input wire logic [tief_pkg::NCH-1:0] extCountClockPin,
	// level interrupt
	output logic irq
);
	import tief_pkg::*;

	logic awHeld, next_awHeld; // address accepted, waiting for data
	logic [11:0] awIdx, next_awIdx; // register index of the write
	logic wHeld, next_wHeld; // data accepted
	logic [31:0] wData, next_wData;
	logic [3:0] wStrb, next_wStrb;
	logic next_bvalid;
	logic [1:0] next_bresp;
	logic next_rvalid;
	logic [31:0] next_rdata;
	logic [1:0] next_rresp;
	logic wrEn; // write executes this cycle
	logic wrByte; // byte lane 0 present
	logic [11:0] arIdx;
	logic [1:0] presc, next_presc; // filter clock divider
	logic filtTick; // one main clock in four
	logic [7:0] ctrl, next_ctrl; // count enables and sources
	logic [7:0] mask, next_mask; // interrupt mask
	logic [7:0] status, next_status; // sticky capture events
	logic [7:0] capEvt; // capture events, two per channel
	logic [7:0] esQ [NCH];
	logic [7:0] nwQ [NCH];
	logic [15:0] cntQ [NCH];
	logic [15:0] cap0Q [NCH];
	logic [15:0] cap1Q [NCH];

	// true when an index names a register
	function automatic logic mapped(input logic [11:0] idx);
		logic hit;
		hit = idx == IDX_CTRL || idx == IDX_STAT || idx == IDX_MASK;
		for (int c = 0; c < NCH; c++) begin
			hit = hit || idx == IDX_ES[c][11:0] || idx == IDX_NW[c][11:0];
			hit = hit || idx == IDX_CAP0[c] || idx == IDX_CAP1[c];
			hit = hit || idx == IDX_CNT[c];
		end
		return hit;
	endfunction

	// each channel holds address and data until both are in
	assign awready = !awHeld;
	assign wready = !wHeld;
	// one read at a time; a new address waits for the old answer
	assign arready = !rvalid;
	assign wrEn = awHeld && wHeld && !bvalid;
	// only accesses that carry the low byte change a register
	assign wrByte = wStrb[0];
	assign arIdx = araddr[13:2];
	assign filtTick = presc == FILT_DIV_LAST;

	// bus channel bookkeeping
	always_comb begin
		next_awHeld = awHeld;
		next_awIdx = awIdx;
		next_wHeld = wHeld;
		next_wData = wData;
		next_wStrb = wStrb;
		next_bvalid = bvalid;
		next_bresp = bresp;
		next_rvalid = rvalid;
		next_rdata = rdata;
		next_rresp = rresp;
		if (awvalid && awready) begin
			next_awHeld = 1'b1;
			next_awIdx = awaddr[13:2];
		end
		if (wvalid && wready) begin
			next_wHeld = 1'b1;
			next_wData = wdata;
			next_wStrb = wstrb;
		end
		// response follows both halves by one cycle
		if (wrEn) begin
			next_bvalid = 1'b1;
			next_bresp = mapped(awIdx) ? RESP_OKAY : RESP_SLVERR;
			next_awHeld = 1'b0;
			next_wHeld = 1'b0;
		end else if (bvalid && bready) begin
			next_bvalid = 1'b0;
		end
		// read data is captured with the address
		if (arvalid && arready) begin
			next_rvalid = 1'b1;
			next_rresp = mapped(arIdx) ? RESP_OKAY : RESP_SLVERR;
			next_rdata = 32'h0000_0000;
			if (arIdx == IDX_CTRL) begin
				next_rdata = {24'h00_0000, ctrl};
			end
			if (arIdx == IDX_STAT) begin
				next_rdata = {24'h00_0000, status};
			end
			if (arIdx == IDX_MASK) begin
				next_rdata = {24'h00_0000, mask};
			end
			for (int c = 0; c < NCH; c++) begin
				if (arIdx == IDX_ES[c][11:0]) begin
					next_rdata = {24'h00_0000, esQ[c]};
				end
				if (arIdx == IDX_NW[c][11:0]) begin
					next_rdata = {24'h00_0000, nwQ[c]};
				end
				if (arIdx == IDX_CAP0[c]) begin
					next_rdata = {16'h0000, cap0Q[c]};
				end
				if (arIdx == IDX_CAP1[c]) begin
					next_rdata = {16'h0000, cap1Q[c]};
				end
				if (arIdx == IDX_CNT[c]) begin
					next_rdata = {16'h0000, cntQ[c]};
				end
			end
		end else if (rvalid && rready) begin
			next_rvalid = 1'b0;
		end
	end

	// block-level control, mask and sticky status
	always_comb begin
		next_presc = presc + 2'h1;
		next_ctrl = ctrl;
		next_mask = mask;
		next_status = status;
		if (wrEn && wrByte && awIdx == IDX_CTRL) begin
			next_ctrl = wData[7:0];
		end
		if (wrEn && wrByte && awIdx == IDX_MASK) begin
			next_mask = wData[7:0];
		end
		if (wrEn && wrByte && awIdx == IDX_STAT) begin
			next_status = status & ~wData[7:0];
		end
		// new events win over a clear in the same cycle
		next_status = next_status | capEvt;
	end

	// interrupt is high while any unmasked event is pending
	assign irq = |(status & mask);

	// bus and control registers
	always_ff @(posedge clk) begin
		if (reset) begin
			awHeld <= 1'b0;
			awIdx <= 12'h000;
			wHeld <= 1'b0;
			wData <= 32'h0000_0000;
			wStrb <= 4'h0;
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= RESP_OKAY;
			presc <= 2'h0;
			ctrl <= CTRL_RST;
			mask <= MASK_RST;
			status <= STAT_RST;
		end else begin
			awHeld <= next_awHeld;
			awIdx <= next_awIdx;
			wHeld <= next_wHeld;
			wData <= next_wData;
			wStrb <= next_wStrb;
			bvalid <= next_bvalid;
			bresp <= next_bresp;
			rvalid <= next_rvalid;
			rdata <= next_rdata;
			rresp <= next_rresp;
			presc <= next_presc;
			ctrl <= next_ctrl;
			mask <= next_mask;
			status <= next_status;
		end
	end

	// per-channel registers, filters, counter and captures
	for (genvar c = 0; c < NCH; c++) begin : g_ch
		logic [7:0] es, next_es; // valid edge select
		logic [7:0] nw, next_nw; // noise width
		logic [15:0] cnt, next_cnt; // channel counter
		logic [15:0] cap0, next_cap0;
		logic [15:0] cap1, next_cap1;
		logic hit0, hit1, hitClk; // filtered valid edges
		logic ce, src;

		// each pin takes its own edge field
		tief_filter u_cap0 (
			.clk(clk),
			.reset(reset),
			.pinIn(captureInput0[c]),
			.filtTick(filtTick),
			.widthCode(nw[1:0]),
			.edgeCode(es[ES_CAP0_LSB+:2]),
			.edgeHit(hit0)
		);
		tief_filter u_cap1 (
			.clk(clk),
			.reset(reset),
			.pinIn(captureInput1[c]),
			.filtTick(filtTick),
			.widthCode(nw[1:0]),
			.edgeCode(es[ES_CAP1_LSB+:2]),
			.edgeHit(hit1)
		);
		tief_filter u_clk (
			.clk(clk),
			.reset(reset),
			.pinIn(extCountClockPin[c]),
			.filtTick(filtTick),
			.widthCode(nw[1:0]),
			.edgeCode(es[ES_CLK_LSB+:2]),
			.edgeHit(hitClk)
		);

		assign ce = ctrl[CTRL_CE_LSB+c];
		assign src = ctrl[CTRL_SRC_LSB+c];

		// register writes, counting and capture
		always_comb begin
			next_es = es;
			next_nw = nw;
			next_cnt = cnt;
			next_cap0 = cap0;
			next_cap1 = cap1;
			// reserved bits are dropped, read as zero
			if (wrEn && wrByte && awIdx == IDX_ES[c][11:0]) begin
				next_es = wData[7:0] & ES_WMASK;
			end
			// width upper bits are dropped, read as zero
			if (wrEn && wrByte && awIdx == IDX_NW[c][11:0]) begin
				next_nw = wData[7:0] & NW_WMASK;
			end
			// external source counts filtered pin edges
			if (!ce) begin
				next_cnt = CNT_RST;
			end else if (src ? hitClk : filtTick) begin
				next_cnt = cnt + 16'h0001;
			end
			// valid capture edge latches the counter
			if (hit0) begin
				next_cap0 = cnt;
			end
			if (hit1) begin
				next_cap1 = cnt;
			end
		end

		always_ff @(posedge clk) begin
			if (reset) begin
				es <= ES_RST;
				nw <= NW_RST;
				cnt <= CNT_RST;
				cap0 <= CNT_RST;
				cap1 <= CNT_RST;
			end else begin
				es <= next_es;
				nw <= next_nw;
				cnt <= next_cnt;
				cap0 <= next_cap0;
				cap1 <= next_cap1;
			end
		end

		assign esQ[c] = es;
		assign nwQ[c] = nw;
		assign cntQ[c] = cnt;
		assign cap0Q[c] = cap0;
		assign cap1Q[c] = cap1;
		assign capEvt[2*c] = hit0;
		assign capEvt[2*c+1] = hit1;
	end

	// capture holds the counter value seen at the edge
	a_capture_value: assert property (@(posedge clk) disable iff (reset)
		g_ch[0].hit0 |=> cap0Q[0] == $past(cntQ[0]))
		else $error("capture missed counter value");
	// an event stays pending across a clear in the same cycle
	a_sticky_set: assert property (@(posedge clk) disable iff (reset)
		capEvt[0] |=> status[0] ##1 (status[0] || $past(wrEn)))
		else $error("capture event lost");
	// reserved edge bits never read back set
	a_es_reserved: assert property (@(posedge clk) disable iff (reset)
		esQ[0][5:4] == 2'b00)
		else $error("reserved edge bits set");
	// width register comes out of reset at its default
	a_nw_reset: assert property (@(posedge clk)
		$past(reset) |-> nwQ[2] == NW_RST && esQ[2] == ES_RST)
		else $error("wrong register reset value");
	// write without the low byte lane leaves edge register alone
	a_byte_access: assert property (@(posedge clk) disable iff (reset)
		wrEn && !wrByte |=> $stable(esQ[0]) && $stable(nwQ[0]))
		else $error("partial write changed a register");
	// external source advances only on a clock pin edge
	a_ext_count: assert property (@(posedge clk) disable iff (reset)
		ctrl[CTRL_CE_LSB+2] && ctrl[CTRL_SRC_LSB+2] && !g_ch[2].hitClk
		|=> $stable(cntQ[2]))
		else $error("external counter moved without edge");
	// write answer one cycle after both halves
	a_write_answer: assert property (@(posedge clk) disable iff (reset)
		wrEn |=> bvalid ##0 (!bready or ##1 !bvalid))
		else $error("write response late");
	// read answer one cycle after address
	a_read_answer: assert property (@(posedge clk) disable iff (reset)
		arvalid && arready |=> rvalid)
		else $error("read response late");
	c_capture: cover property (@(posedge clk) disable iff (reset)
		g_ch[0].hit0 ##1 irq);
	c_ext_count: cover property (@(posedge clk) disable iff (reset)
		ctrl[CTRL_SRC_LSB+2] && g_ch[2].hitClk);
	c_write: cover property (@(posedge clk) disable iff (reset)
		bvalid && bready);
endmodule

//--- hw/tief_pkg.sv
// constants and types shared by the timer input edge filter block
package tief_pkg;
	// number of timer channels with conditioned inputs
	localparam int NCH = 4;
	// register indices; the byte address is four times the index
	localparam logic [31:0] IDX_ES [NCH] = '{32'hFFFF_F609, 32'hFFFF_F629,
		32'hFFFF_F649, 32'hFFFF_F669};
	localparam logic [31:0] IDX_NW [NCH] = '{32'hFFFF_F610, 32'hFFFF_F630,
		32'hFFFF_F650, 32'hFFFF_F670};
	// block-level registers and per-channel captures and counters, indices in the same space
	localparam logic [11:0] IDX_CTRL = 12'h700;
	localparam logic [11:0] IDX_STAT = 12'h701;
	localparam logic [11:0] IDX_MASK = 12'h702;
	localparam logic [11:0] IDX_CAP0 [NCH] = '{12'h710, 12'h714, 12'h718,
		12'h71C};
	localparam logic [11:0] IDX_CAP1 [NCH] = '{12'h711, 12'h715, 12'h719,
		12'h71D};
	localparam logic [11:0] IDX_CNT [NCH] = '{12'h712, 12'h716, 12'h71A,
		12'h71E};
	// reset values
	localparam logic [7:0] ES_RST = 8'h00;
	localparam logic [7:0] NW_RST = 8'h02;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] STAT_RST = 8'h00;
	localparam logic [7:0] MASK_RST = 8'h00;
	localparam logic [15:0] CNT_RST = 16'h0000;
	// field positions inside the edge-select register
	localparam int ES_CAP0_LSB = 0;
	localparam int ES_CAP1_LSB = 2;
	localparam int ES_CLK_LSB = 6;
	// writable bits; reserved ones read back as zero
	localparam logic [7:0] ES_WMASK = 8'hCF;
	localparam logic [7:0] NW_WMASK = 8'h03;
	// control register fields: count enable low nibble, source high nibble
	localparam int CTRL_CE_LSB = 0;
	localparam int CTRL_SRC_LSB = 4;
	// filter clock is the main clock divided by four; this is the last prescaler count
	localparam logic [1:0] FILT_DIV_LAST = 2'h3;
	// consecutive filter clocks for each width code
	localparam logic [2:0] FILT_N2 = 3'h2;
	localparam logic [2:0] FILT_N3 = 3'h3;
	localparam logic [2:0] FILT_N5 = 3'h5;
	// bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// valid edge codes
	typedef enum logic [1:0] {
		EDGE_FALL = 2'b00,
		EDGE_RISE = 2'b01,
		EDGE_BAD = 2'b10,
		EDGE_BOTH = 2'b11
	} tief_edge_t;
	// noise width codes
	typedef enum logic [1:0] {
		FW_THRU = 2'b00,
		FW_2 = 2'b01,
		FW_3 = 2'b10,
		FW_5 = 2'b11
	} tief_width_t;
endpackage

//--- hw/tief_filter.sv
// per-pin synchroniser, digital noise filter and valid edge detector
`timescale 1ns/1ps
module tief_filter (
	input wire logic clk,
	input wire logic reset,
	input wire logic pinIn,
	input wire logic filtTick,
	input wire logic [1:0] widthCode,
	input wire logic [1:0] edgeCode,
	output logic edgeHit
);
	import tief_pkg::*;
	logic sync1, next_sync1; // first stage, read by sync2 only
	logic sync2, next_sync2; // safe copy of the pin
	logic stable, next_stable; // filtered level
	logic prevStable, next_prevStable; // last filtered level
	logic [2:0] cnt, next_cnt; // run of differing samples
	logic [2:0] target; // run length needed
	logic next_edgeHit;
	logic rise, fall;

	// filter and edge detection
	always_comb begin
		next_sync1 = pinIn;
		next_sync2 = sync1;
		next_stable = stable;
		next_cnt = cnt;
		next_prevStable = stable;
		unique case (tief_width_t'(widthCode))
			FW_2: target = FILT_N2;
			FW_3: target = FILT_N3;
			FW_5: target = FILT_N5;
			FW_THRU: target = FILT_N2;
		endcase
		if (widthCode == FW_THRU) begin
			next_stable = sync2;
			next_cnt = 3'h0;
		end else if (filtTick) begin
			// level must hold for the whole run
			if (sync2 == stable) begin
				next_cnt = 3'h0;
			end else if (cnt + 3'h1 >= target) begin
				next_stable = sync2;
				next_cnt = 3'h0;
			end else begin
				next_cnt = cnt + 3'h1;
			end
		end
		rise = stable & ~prevStable;
		fall = ~stable & prevStable;
		// edge code picks the valid edge, code 10 gives none
		unique case (tief_edge_t'(edgeCode))
			EDGE_FALL: next_edgeHit = fall;
			EDGE_RISE: next_edgeHit = rise;
			EDGE_BOTH: next_edgeHit = rise | fall;
			EDGE_BAD: next_edgeHit = 1'b0;
		endcase
	end

	// registers only
	always_ff @(posedge clk) begin
		if (reset) begin
			sync1 <= 1'b0;
			sync2 <= 1'b0;
			stable <= 1'b0;
			prevStable <= 1'b0;
			cnt <= 3'h0;
			edgeHit <= 1'b0;
		end else begin
			sync1 <= next_sync1;
			sync2 <= next_sync2;
			stable <= next_stable;
			prevStable <= next_prevStable;
			cnt <= next_cnt;
			edgeHit <= next_edgeHit;
		end
	end

	// prohibited code never yields an edge
	a_bad_code: assert property (@(posedge clk) disable iff (reset)
		edgeCode == EDGE_BAD |=> !edgeHit)
		else $error("edge seen with prohibited code");
	// width 2 changes level only after two differing ticks
	a_filter_hold: assert property (@(posedge clk) disable iff (reset)
		widthCode == FW_2 && $past(widthCode) == FW_2 && $changed(stable)
		|-> $past(cnt) == 3'h1 && $past(filtTick))
		else $error("filter passed level too early");
	// rising code flags only rising edges
	a_rise_only: assert property (@(posedge clk) disable iff (reset)
		edgeCode == EDGE_RISE && fall |=> !edgeHit)
		else $error("falling edge taken in rising mode");
	c_both_edge: cover property (@(posedge clk) disable iff (reset)
		edgeCode == EDGE_BOTH ##1 edgeHit);
endmodule

//--- testbench/tief_pin_model.sv
// far-side pin driver for the timer input pins
`timescale 1ns/1ps
module tief_pin_model (
	input wire logic clk,
	input wire logic [11:0] want,
	output logic [3:0] pin0,
	output logic [3:0] pin1,
	output logic [3:0] pinClk
);
	// pins move one clock after the request, on the same rising edge the block samples them
	always_ff @(posedge clk) begin
		{pinClk, pin1, pin0} <= want;
	end
endmodule

//--- testbench/timer_input_edge_filter_test.sv
// self-checking bench for the timer input edge filter block
`timescale 1ns/1ps
module timer_input_edge_filter_test;
	import tief_pkg::*;
	localparam logic [31:0] A_CTRL = {18'h0, IDX_CTRL, 2'b00};
	localparam logic [31:0] A_STAT = {18'h0, IDX_STAT, 2'b00};
	localparam logic [31:0] A_MASK = {18'h0, IDX_MASK, 2'b00};
	localparam logic [31:0] A_BAD = 32'h0000_1FC0;
	logic clk, reset, irq;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic [31:0] awaddr, wdata, araddr, rdata, got;
	logic [3:0] wstrb, cap0, cap1, extClk;
	logic [1:0] bresp, rresp, resp;
	// pin requests: [3:0] capture 0, [7:4] capture 1, [11:8] count clock
	logic [11:0] want;
	int n_fail = 0;
	int total_checks = 0;
	int cyc = 0;

	tief_top DUT (.clk(clk), .reset(reset), .awvalid(awvalid),
		.awready(awready), .awaddr(awaddr), .wvalid(wvalid),
		.wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
		.bready(bready), .bresp(bresp), .arvalid(arvalid),
		.arready(arready), .araddr(araddr), .rvalid(rvalid),
		.rready(rready), .rdata(rdata), .rresp(rresp),
		.captureInput0(cap0), .captureInput1(cap1),
		.extCountClockPin(extClk), .irq(irq));
	tief_pin_model PINS (.clk(clk), .want(want), .pin0(cap0),
		.pin1(cap1), .pinClk(extClk));

	// 200 MHz clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// hang guard: the whole run needs well under this many cycles
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			n_fail++;
			report_and_stop();
		end
	end

	task automatic report_and_stop();
		$display("checks %0d failures %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	// readies are sampled at the falling edge, where nothing moves
	task automatic axiWr(input logic [31:0] a, input logic [31:0] d);
		logic aNow, wNow;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(negedge clk);
			aNow = awvalid & awready;
			wNow = wvalid & wready;
			@(posedge clk);
			if (aNow) awvalid <= 1'b0;
			if (wNow) wvalid <= 1'b0;
		end while ((awvalid & !aNow) | (wvalid & !wNow));
		do @(negedge clk); while (!bvalid);
		resp = bresp;
		@(posedge clk);
		bready <= 1'b0;
	endtask

	task automatic axiRd(input logic [31:0] a);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(negedge clk); while (!arready);
		@(posedge clk);
		arvalid <= 1'b0;
		do @(negedge clk); while (!rvalid);
		got = rdata;
		resp = rresp;
		@(posedge clk);
		rready <= 1'b0;
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		axiWr(a, d);
		chk({30'h0, resp}, {30'h0, RESP_OKAY});
	endtask

	task automatic rd(input logic [31:0] a, input logic [31:0] e);
		axiRd(a);
		chk(got, e);
		chk({30'h0, resp}, {30'h0, RESP_OKAY});
	endtask

	// byte address of a register index
	function automatic logic [31:0] ba(input logic [31:0] i);
		return {i[29:0], 2'b00};
	endfunction

	// pin high for len clocks, then low, then let the filter settle
	task automatic pulse(input int i, input int len);
		@(posedge clk);
		want[i] <= 1'b1;
		repeat (len) @(posedge clk);
		want[i] <= 1'b0;
		repeat (40) @(posedge clk);
	endtask

	task automatic setPin(input int i, input logic v);
		@(posedge clk);
		want[i] <= v;
		repeat (16) @(posedge clk);
	endtask

	task automatic testReset();
		for (int c = 0; c < NCH; c++) begin
			rd(ba(IDX_ES[c]), 32'h0000_0000);
			rd(ba(IDX_NW[c]), 32'h0000_0002);
		end
		rd(A_CTRL, 32'h0000_0000);
		rd(A_STAT, 32'h0000_0000);
		rd(A_MASK, 32'h0000_0000);
		// unmapped place answers with an error and no data
		axiRd(A_BAD);
		chk({30'h0, resp}, {30'h0, RESP_SLVERR});
		chk(got, 32'h0000_0000);
		axiWr(A_BAD, 32'h0000_00FF);
		chk({30'h0, resp}, {30'h0, RESP_SLVERR});
	endtask

	task automatic testFields();
		// reserved bits must not stick
		wr(ba(IDX_ES[0]), 32'h0000_00FF);
		rd(ba(IDX_ES[0]), 32'h0000_00CF);
		// a write without the low byte lane must leave the register alone
		wstrb <= 4'hE;
		wr(ba(IDX_ES[0]), 32'h0000_0000);
		wstrb <= 4'hF;
		rd(ba(IDX_ES[0]), 32'h0000_00CF);
		wr(ba(IDX_ES[1]), 32'h0000_0041);
		rd(ba(IDX_ES[1]), 32'h0000_0041);
		wr(ba(IDX_NW[0]), 32'h0000_00FF);
		rd(ba(IDX_NW[0]), 32'h0000_0003);
	endtask

	// every edge code on capture 0 of channel 0, through mode
	task automatic testEdges();
		logic r, f;
		wr(A_CTRL, 32'h0000_0000);
		wr(ba(IDX_NW[0]), 32'h0000_0000);
		for (int k = 0; k < 4; k++) begin
			r = (k == 1) || (k == 3);
			f = (k == 0) || (k == 3);
			wr(A_CTRL, 32'h0000_0000);
			wr(ba(IDX_ES[0]), k);
			wr(A_CTRL, 32'h0000_0001);
			wr(A_STAT, 32'h0000_00FF);
			setPin(0, 1'b1);
			rd(A_STAT, {31'h0, r});
			wr(A_STAT, 32'h0000_00FF);
			setPin(0, 1'b0);
			rd(A_STAT, {31'h0, f});
		end
	endtask

	task automatic chkIrq(input logic e);
		@(negedge clk);
		chk({31'h0, irq}, {31'h0, e});
	endtask

	task automatic testIrq();
		wr(A_CTRL, 32'h0000_0000);
		wr(ba(IDX_ES[0]), 32'h0000_0001);
		wr(A_CTRL, 32'h0000_0001);
		wr(A_STAT, 32'h0000_00FF);
		wr(A_MASK, 32'h0000_0001);
		chkIrq(1'b0);
		setPin(0, 1'b1);
		chkIrq(1'b1);
		wr(A_MASK, 32'h0000_0000);
		chkIrq(1'b0);
		wr(A_MASK, 32'h0000_0001);
		chkIrq(1'b1);
		wr(A_STAT, 32'h0000_0001);
		chkIrq(1'b0);
		rd(A_STAT, 32'h0000_0000);
		setPin(0, 1'b0);
	endtask

	// glitches shorter than the width are dropped, long levels pass
	task automatic testFilter();
		int n;
		wr(A_CTRL, 32'h0000_0000);
		wr(ba(IDX_ES[1]), 32'h0000_0001);
		for (int k = 1; k < 4; k++) begin
			n = (k == 1) ? 2 : (k == 2) ? 3 : 5;
			wr(ba(IDX_NW[1]), k);
			wr(A_STAT, 32'h0000_00FF);
			pulse(1, 4 * (n - 1));
			rd(A_STAT, 32'h0000_0000);
			pulse(1, 4 * n + 8);
			rd(A_STAT, 32'h0000_0004);
		end
	endtask

	// external pin counting on both edges, then a capture of the count
	task automatic testCount();
		wr(A_CTRL, 32'h0000_0000);
		wr(ba(IDX_NW[2]), 32'h0000_0000);
		wr(A_CTRL, 32'h0000_0044);
		wr(ba(IDX_ES[2]), 32'h0000_00C4);
		wr(A_STAT, 32'h0000_00FF);
		for (int p = 0; p < 3; p++) pulse(10, 8);
		rd(ba({20'h0, IDX_CNT[2]}), 32'h0000_0006);
		pulse(6, 8);
		rd(ba({20'h0, IDX_CAP1[2]}), 32'h0000_0006);
		rd(A_STAT, 32'h0000_0020);
		// dropping the count enable clears the counter
		wr(A_CTRL, 32'h0000_0000);
		rd(ba({20'h0, IDX_CNT[2]}), 32'h0000_0000);
	endtask

	initial begin
		reset = 1'b1;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h0;
		{awaddr, wdata, araddr} = 96'h0;
		wstrb = 4'hF;
		want = 12'h000;
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		testReset();
		testFields();
		testEdges();
		testIrq();
		testFilter();
		testCount();
		report_and_stop();
	end
endmodule
